// ==== ppio_defs.vh ====
// constants for the port pin input and override block
`ifndef PPIO_DEFS_VH
`define PPIO_DEFS_VH

// register byte addresses on the ahb-lite slave
`define PPIO_ADDR_OUT 4'h0
`define PPIO_ADDR_DIR 4'h4
`define PPIO_ADDR_PUE 4'h8
`define PPIO_ADDR_PIN 4'hc
// address bits decoded inside the register window
`define PPIO_ADDR_HI 3
// default pin count of one port
`define PPIO_NPINS 4
// htrans encodings used
`define PPIO_HTRANS_NONSEQ 2'b10
`define PPIO_HTRANS_SEQ 2'b11
// reset value of all port registers
`define PPIO_RST_VAL 1'b0

`endif

// ==== ppio_sync.v ====
// two-stage pad synchronizer for one pin
`include "ppio_defs.vh"

module ppio_sync (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // pad level: gated input, or the raw pad for the wake flag instance
  input wire din,
  // synchronized level
  output reg dout_q
);

  reg stage_q;

  // first stage stands in for the sync latch: open while clock is high,
  // closed on the falling edge; only dout_q reads it
  // half a period to settle is the price of one-period read-back
  always @(negedge clock) begin
    if (sys_rst) begin
      stage_q <= `PPIO_RST_VAL;
    end else begin
      stage_q <= din;
    end
  end

  // sample stage loads the held level on the next rising edge
  always @(posedge clock) begin
    if (sys_rst) begin
      dout_q <= `PPIO_RST_VAL;
    end else begin
      dout_q <= stage_q;
    end
  end

endmodule

// ==== ppio_port.v ====
// one general-purpose i/o port: registers, overrides, input path
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`include "ppio_defs.vh"

module ppio_port #(
  parameter NPINS = `PPIO_NPINS
) (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // pads
  input wire [NPINS-1:0] pad_in,
  output wire [NPINS-1:0] pad_out,
  output wire [NPINS-1:0] pad_oe,
  output wire [NPINS-1:0] pad_pullup_en,
  // sleep controller, shared by all ports
  input wire sleep_deep,
  // per-pin overrides from peripheral modules
  input wire [NPINS-1:0] pullup_override_en,
  input wire [NPINS-1:0] pullup_override_val,
  input wire [NPINS-1:0] direction_override_en,
  input wire [NPINS-1:0] direction_override_val,
  input wire [NPINS-1:0] value_override_en,
  input wire [NPINS-1:0] value_override_val,
  input wire [NPINS-1:0] toggle_override_en,
  input wire [NPINS-1:0] input_gate_override_en,
  input wire [NPINS-1:0] input_gate_override_val,
  // external interrupt enables and wake flag set requests
  input wire [NPINS-1:0] ext_int_pin_en,
  input wire [NPINS-1:0] ext_int_req_en,
  input wire [NPINS-1:0] ext_int_edge_mode,
  output reg [NPINS-1:0] ext_int_wake_set_q,
  // taps to alternate function modules
  output wire [NPINS-1:0] alt_function_input_tap,
  output wire [NPINS-1:0] analog_pad_link
);

  reg [NPINS-1:0] output_latch_bit_q;
  reg [NPINS-1:0] pin_direction_bit_q;
  reg [NPINS-1:0] pullup_select_bit_q;
  wire [NPINS-1:0] pin_sample_bit;
  reg [NPINS-1:0] output_latch_bit_d;
  reg wr_pend_q;
  reg [3:0] wr_addr_q;
  reg rd_pend_q;
  reg [3:0] rd_addr_q;
  reg [31:0] rdata_q;
  reg sleep_deep_q;
  wire [NPINS-1:0] drv_en;
  wire [NPINS-1:0] drv_val;
  wire [NPINS-1:0] in_en;
  wire [NPINS-1:0] gated_in;
  wire [NPINS-1:0] sleep_clamp;
  // ungated pad level after two stages, for the wake flag only
  wire [NPINS-1:0] pad_level_sync;
  wire wr_out;
  wire wr_pin;
  wire addr_phase;

  // one shared write and read strobe set per port
  assign addr_phase = hsel & hready & htrans[1];
  assign wr_out = wr_pend_q & (wr_addr_q == `PPIO_ADDR_OUT);
  assign wr_pin = wr_pend_q & (wr_addr_q == `PPIO_ADDR_PIN);

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // capture address phase for the following data phase
  always @(posedge clock) begin
    if (sys_rst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= 4'h0;
      rd_addr_q <= 4'h0;
    end else begin
      wr_pend_q <= addr_phase & hwrite;
      rd_pend_q <= addr_phase & ~hwrite;
      wr_addr_q <= haddr[`PPIO_ADDR_HI:0];
      rd_addr_q <= haddr[`PPIO_ADDR_HI:0];
    end
  end

  // read data registered one cycle after the address phase
  always @(posedge clock) begin
    if (sys_rst) begin
      rdata_q <= 32'h0;
    end else if (addr_phase & ~hwrite) begin
      rdata_q <= 32'h0;
      case (haddr[`PPIO_ADDR_HI:0])
        `PPIO_ADDR_OUT: rdata_q[NPINS-1:0] <= output_latch_bit_q;
        `PPIO_ADDR_DIR: rdata_q[NPINS-1:0] <= pin_direction_bit_q;
        `PPIO_ADDR_PUE: rdata_q[NPINS-1:0] <= pullup_select_bit_q;
        `PPIO_ADDR_PIN: rdata_q[NPINS-1:0] <= pin_sample_bit;
        default: rdata_q <= 32'h0;
      endcase
    end
  end

  // output latch next value: write, then toggle by sample write and override
  always @* begin
    output_latch_bit_d = output_latch_bit_q;
    if (wr_out) begin
      output_latch_bit_d = hwdata[NPINS-1:0];
    end
    if (wr_pin) begin
      output_latch_bit_d = output_latch_bit_d ^ hwdata[NPINS-1:0];
    end
    output_latch_bit_d = output_latch_bit_d ^ toggle_override_en;
  end

  // port registers
  always @(posedge clock) begin
    if (sys_rst) begin
      output_latch_bit_q <= {NPINS{`PPIO_RST_VAL}};
      pin_direction_bit_q <= {NPINS{`PPIO_RST_VAL}};
      pullup_select_bit_q <= {NPINS{`PPIO_RST_VAL}};
    end else begin
      output_latch_bit_q <= output_latch_bit_d;
      if (wr_pend_q && wr_addr_q == `PPIO_ADDR_DIR) begin
        pin_direction_bit_q <= hwdata[NPINS-1:0];
      end
      if (wr_pend_q && wr_addr_q == `PPIO_ADDR_PUE) begin
        pullup_select_bit_q <= hwdata[NPINS-1:0];
      end
    end
  end

  // sleep level comes from same clock domain, so no synchronizer
  always @(posedge clock) begin
    if (sys_rst) begin
      sleep_deep_q <= 1'b0;
    end else begin
      sleep_deep_q <= sleep_deep;
    end
  end

  // output drive; reset gates drivers combinationally, no clock needed
  assign drv_en = sys_rst ? {NPINS{1'b0}} :
    ((direction_override_en & direction_override_val) |
     (~direction_override_en & pin_direction_bit_q));
  assign drv_val = (value_override_en & value_override_val) |
    (~value_override_en & output_latch_bit_q);
  assign pad_oe = drv_en;
  assign pad_out = drv_val & drv_en;

  // pull-up, forced off throughout reset
  assign pad_pullup_en = sys_rst ? {NPINS{1'b0}} :
    ((pullup_override_en & pullup_override_val) |
     (~pullup_override_en & pullup_select_bit_q));

  // clamp in deep sleep unless an enabled external interrupt pin
  assign sleep_clamp = {NPINS{sleep_deep}} & ~(ext_int_pin_en & ext_int_req_en);
  assign in_en = (input_gate_override_en & input_gate_override_val) |
    (~input_gate_override_en & ~sleep_clamp);
  assign gated_in = pad_in & in_en;

  // raw taps before the synchronizer: alternate input after the gate, analog link before it
  assign alt_function_input_tap = gated_in;
  assign analog_pad_link = pad_in;

  // the sleep level falling on wake produces the edge the flag logic expects
  always @(posedge clock) begin
    if (sys_rst) begin
      ext_int_wake_set_q <= {NPINS{1'b0}};
    end else begin
      ext_int_wake_set_q <= {NPINS{sleep_deep_q & ~sleep_deep}} & pad_level_sync &
        ext_int_pin_en & ~ext_int_req_en & ext_int_edge_mode;
    end
  end

  // two synchronizers per pin, gated input and raw wake level; software drive shows one period later
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_sync
      ppio_sync u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .din(gated_in[gi]),
        .dout_q(pin_sample_bit[gi])
      );
      // raw pad must not reach flag logic unsynchronized
      ppio_sync u_wake_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .din(pad_in[gi]),
        .dout_q(pad_level_sync[gi])
      );
    end
  endgenerate

endmodule

// ==== ppio_port_checker.sv ====
// assertions on pads, taps and overrides of one port
module ppio_port_checker #(parameter NPINS = 4) (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // pads and taps
  input wire [NPINS-1:0] pad_in,
  input wire [NPINS-1:0] pad_out,
  input wire [NPINS-1:0] pad_oe,
  input wire [NPINS-1:0] pad_pullup_en,
  input wire [NPINS-1:0] analog_pad_link,
  input wire [NPINS-1:0] alt_function_input_tap,
  // sleep and overrides
  input wire sleep_deep,
  input wire [NPINS-1:0] pullup_override_en,
  input wire [NPINS-1:0] pullup_override_val,
  input wire [NPINS-1:0] direction_override_en,
  input wire [NPINS-1:0] direction_override_val,
  input wire [NPINS-1:0] input_gate_override_en,
  input wire [NPINS-1:0] input_gate_override_val,
  input wire [NPINS-1:0] ext_int_pin_en,
  input wire [NPINS-1:0] ext_int_req_en
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // pins that escape the clamp: enabled interrupt or gate override
  wire [NPINS-1:0] free = (ext_int_pin_en & ext_int_req_en) | input_gate_override_en;
  // reset must not wait for a clock edge, so never disabled
  property p_rst; disable iff (1'b0) sys_rst |-> (pad_oe | pad_pullup_en) == '0; endproperty
  a_rst: assert property (p_rst) else $error("pads live in reset");
  property p_dir; ((pad_oe ^ direction_override_val) & direction_override_en) == '0; endproperty
  a_dir: assert property (p_dir) else $error("driver ignores override");
  property p_pu; ((pad_pullup_en ^ pullup_override_val) & pullup_override_en) == '0; endproperty
  a_pu: assert property (p_pu) else $error("pull-up ignores override");
  property p_hiz; (pad_out & ~pad_oe) == '0; endproperty
  a_hiz: assert property (p_hiz) else $error("level without driver");
  property p_ana; analog_pad_link == pad_in; endproperty
  a_ana: assert property (p_ana) else $error("analog link differs");
  property p_gate; ((alt_function_input_tap ^ (pad_in & input_gate_override_val))
    & input_gate_override_en) == '0; endproperty
  a_gate: assert property (p_gate) else $error("gate override ignored");
  property p_clamp; sleep_deep |-> (alt_function_input_tap & ~free) == '0; endproperty
  a_clamp: assert property (p_clamp) else $error("input not clamped");
  property p_awake; !sleep_deep |->
    ((alt_function_input_tap ^ pad_in) & ~input_gate_override_en) == '0; endproperty
  a_awake: assert property (p_awake) else $error("tap differs from pad");
  c_sleep: cover property (sleep_deep && alt_function_input_tap != '0);
  c_dir: cover property (direction_override_en != '0);
  c_pu: cover property (pullup_override_en != '0);
endmodule

// ==== ppio_pad_model.sv ====
// pad side: outside drivers, pull-ups and floating pins
module ppio_pad_model #(parameter NPINS = 4) (
  // design side
  input wire clock,
  input wire [NPINS-1:0] pad_out,
  input wire [NPINS-1:0] pad_oe,
  input wire [NPINS-1:0] pad_pullup_en,
  // bench side
  input wire [NPINS-1:0] ext_drv,
  input wire [NPINS-1:0] ext_val,
  output wire [NPINS-1:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [NPINS-1:0] float_q = '0;
  // undriven pins wander every cycle so no stale level can pass
  always @(posedge clock) float_q <= ~float_q;
  // own driver wins, then outside driver, then pull-up
  assign pad_in = pad_oe & pad_out | ~pad_oe & (ext_drv & ext_val | ~ext_drv & (pad_pullup_en | float_q));
endmodule

// ==== ppio_port_tb.sv ====
// bench for one port: bus tasks, scenarios and verdict
`include "ppio_defs.vh"
module ppio_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam NPINS = 4;
  logic clock = 0, sys_rst = 1, hsel = 1, hwrite = 0, sleep_deep = 0;
  logic [31:0] haddr = '0, hwdata = '0, r;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] pullup_override_en = '0, pullup_override_val = '0, direction_override_en = '0;
  logic [3:0] direction_override_val = '0, value_override_en = '0, value_override_val = '0;
  logic [3:0] toggle_override_en = '0, input_gate_override_en = '0, input_gate_override_val = '0;
  logic [3:0] ext_int_pin_en = '0, ext_int_req_en = '0, ext_int_edge_mode = '0;
  logic [3:0] ext_drv = 4'hf, ext_val = 4'h0;
  wire hreadyout, hresp;
  wire hready = hreadyout;
  wire [31:0] hrdata;
  wire [3:0] pad_in, pad_out, pad_oe, pad_pullup_en, ext_int_wake_set_q;
  wire [3:0] alt_function_input_tap, analog_pad_link;
  int miscompares = 0, samples_checked = 0;
  ppio_port #(.NPINS(NPINS)) i_ppio_port (.*);
  ppio_pad_model #(.NPINS(NPINS)) i_ppio_pad_model (.*);
  always #50 clock = ~clock;
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // single transfer; waits on hready, read data taken at the data phase edge
  task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(string what, logic [31:0] a, logic [31:0] exp);
    bus(0, a, '0);
    check(what, exp, r);
  endtask
  task automatic t_readback;
    rd("out", `PPIO_ADDR_OUT, '0);
    rd("pin", `PPIO_ADDR_PIN, '0);
    bus(1, `PPIO_ADDR_DIR, 32'hf);
    bus(1, `PPIO_ADDR_OUT, 32'h5);
    @(posedge clock);
    rd("pin", `PPIO_ADDR_PIN, 32'h5);
    check("oe", 32'hf, pad_oe);
    // without the idle cycle the old level still shows
    bus(1, `PPIO_ADDR_OUT, 32'ha);
    rd("pin", `PPIO_ADDR_PIN, 32'h5);
    rd("pin", `PPIO_ADDR_PIN, 32'ha);
    bus(1, `PPIO_ADDR_PIN, 32'h3);
    @(posedge clock);
    rd("out", `PPIO_ADDR_OUT, 32'h9);
    $display("readback test done");
  endtask
  task automatic t_override;
    toggle_override_en <= 4'h8;
    pullup_override_en <= 4'hf;
    pullup_override_val <= 4'h5;
    direction_override_en <= 4'h3;
    direction_override_val <= 4'h1;
    value_override_en <= 4'h1;
    @(posedge clock);
    toggle_override_en <= 4'h0;
    @(posedge clock);
    rd("out", `PPIO_ADDR_OUT, 32'h1);
    check("pu", 32'h5, pad_pullup_en);
    check("oe", 32'hd, pad_oe);
    check("pad", 32'h0, pad_out);
    {pullup_override_en, direction_override_en, value_override_en} <= '0;
    $display("override test done");
  endtask
  task automatic t_sleep;
    bus(1, `PPIO_ADDR_DIR, '0);
    ext_val <= 4'hf;
    ext_int_pin_en <= 4'h3;
    ext_int_req_en <= 4'h1;
    ext_int_edge_mode <= 4'h2;
    input_gate_override_en <= 4'h4;
    input_gate_override_val <= 4'h4;
    sleep_deep <= 1'b1;
    repeat (2) @(posedge clock);
    check("tap", 32'h5, alt_function_input_tap);
    sleep_deep <= 1'b0;
    r = '0;
    // the wake pulse lasts one cycle, so collect it over a short window
    repeat (4) @(negedge clock) r[3:0] = r[3:0] | ext_int_wake_set_q;
    check("wake", 32'h2, r);
    @(posedge clock);
    $display("sleep test done");
  endtask
  task final_report;
    $display("%0d checked, %0d wrong", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_readback;
    t_override;
    t_sleep;
    final_report;
  end
  // hang guard, far beyond the few dozen cycles the tests need
  initial begin
    #100000;
    miscompares++;
    final_report;
  end
endmodule
bind ppio_port ppio_port_checker #(.NPINS(NPINS)) i_ppio_port_checker (.*);
